// *** rtl/sleep_ctl_pkg.sv ***
// Functional notes
// [R1] The controller keeps the sleep request low in normal use, and an undriven request reads as low.
// [R2] Two clock cycles after the sleep request rises the device is in its low-power sleep state; here four edges after the pin.
// [R3] Sleep keeps all internal state, the stored contents included, without loss.
// [R4] Normal operation resumes only after at least 20 ns of recovery once the request falls.
// [R5] Asleep, the device acts deselected, ignores all inputs but the request and floats its outputs.
// [R6] The request is asynchronous and active high, and sleep lasts as long as it stays high.
// [R7] The controller raises the request only after all pending operations have finished.
// [R8] During recovery the controller issues only deselect or read commands.
// [R9] Entry counts rising edges that sample the request high, and aborts if it falls first.
package sleep_ctl_pkg;
  localparam int unsigned CLK_PERIOD_PS      = 25000;
  localparam int unsigned SLEEP_ENTRY_CYCLES = 2;
  localparam int unsigned SLEEP_RECOVERY_PS  = 20000;
  localparam int unsigned RECOVERY_CYCLES_I  =
    (SLEEP_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0]  SLEEP_RECOVERY_CYCLES =
    (RECOVERY_CYCLES_I < 1) ? 2'h1 : RECOVERY_CYCLES_I[1:0];
  localparam logic [1:0]  ENTRY_COUNT_LAST = 2'(SLEEP_ENTRY_CYCLES - 1);
  localparam logic        SYNC_RESET_VALUE = 1'h0;

  typedef enum logic [1:0] {AWAKE, ENTERING, ASLEEP, RECOVERING} power_state_e;
endpackage

// *** rtl/sleep_sync.sv ***
module sleep_sync
  import sleep_ctl_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous level in, synchronous level out.
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  always_comb begin
    state_next.meta   = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{SYNC_RESET_VALUE, SYNC_RESET_VALUE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;
endmodule

// *** rtl/sram_sleep_ctl.sv ***
module sram_sleep_ctl
  import sleep_ctl_pkg::*;
(
  // Clock and reset.
  input  wire logic SYS_CLK,
  input  wire logic RSTN,
  // Sleep request pin from the memory controller.
  input  wire logic SLEEP_REQUEST,
  // Status toward the SRAM core.
  output logic      SLEEP_ACTIVE,
  output logic      DESELECT_FORCE,
  output logic      INPUTS_BLOCKED,
  output logic      OUTPUT_DISABLE,
  output logic      RETAIN_STATE,
  output logic      RECOVERY_ACTIVE,
  output logic      WRITE_BLOCK,
  output logic      READY
);
  typedef struct packed {
    power_state_e state;
    logic [1:0]   count;
    logic         asleep;
    logic         recovering;
    logic         ready;
  } ctl_s;

  ctl_s ctl_reg;
  ctl_s ctl_next;
  logic req_sync;

  // One step of the shared entry and recovery counter.
  function automatic logic [1:0] count_up(input logic [1:0] value);
    return value + 2'h1;
  endfunction

  // An undriven pin is pulled low outside; reset value of the
  // synchroniser also reads as no request. [R1]
  sleep_sync u_sync (
    .clk      (SYS_CLK),
    .rst_n    (RSTN),
    .async_in (SLEEP_REQUEST),
    .sync_out (req_sync)
  );

  // The synchroniser adds latency before the entry count, so the core
  // sees sleep two counted edges after the request is first seen high.
  always_comb begin
    ctl_next = ctl_reg;
    unique case (ctl_reg.state)
      AWAKE: begin
        ctl_next.count = 2'h0;
        if (req_sync) begin // [R9]
          ctl_next.state = ENTERING;
          ctl_next.count = 2'h1;
        end
      end
      ENTERING: begin
        if (!req_sync && ctl_reg.ready) begin // [R9]
          ctl_next.state = AWAKE;
          ctl_next.count = 2'h0;
        end else if (!req_sync) begin // [R4]
          // An entry begun during recovery may not skip the rest of it,
          // so a fall here restarts a full recovery instead.
          ctl_next.state      = RECOVERING;
          ctl_next.recovering = 1'b1;
          ctl_next.count      = 2'h1;
        end else if (ctl_reg.count == ENTRY_COUNT_LAST) begin // [R2]
          ctl_next.state  = ASLEEP;
          ctl_next.asleep = 1'b1;
          ctl_next.ready  = 1'b0;
          ctl_next.count  = 2'h0;
        end else begin
          ctl_next.count = count_up(ctl_reg.count);
        end
      end
      ASLEEP: begin
        if (!req_sync) begin // [R6]
          ctl_next.state      = RECOVERING;
          ctl_next.asleep     = 1'b0;
          ctl_next.recovering = 1'b1;
          ctl_next.count      = 2'h1;
        end
      end
      RECOVERING: begin
        // A request raised again here counts toward entry at once; READY
        // stays low because the recovery was never completed.
        if (req_sync) begin // [R6]
          ctl_next.state      = ENTERING;
          ctl_next.recovering = 1'b0;
          ctl_next.count      = 2'h1;
        end else if (ctl_reg.count >= SLEEP_RECOVERY_CYCLES) begin // [R4]
          ctl_next.state      = AWAKE;
          ctl_next.recovering = 1'b0;
          ctl_next.ready      = 1'b1;
          ctl_next.count      = 2'h0;
        end else begin
          ctl_next.count = count_up(ctl_reg.count);
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_reg <= '{AWAKE, 2'h0, 1'b0, 1'b0, 1'b1};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Each output is a flip-flop bit of the state, never a gate. [R5]
  assign SLEEP_ACTIVE    = ctl_reg.asleep;
  assign DESELECT_FORCE  = ctl_reg.asleep;
  assign INPUTS_BLOCKED  = ctl_reg.asleep;
  assign OUTPUT_DISABLE  = ctl_reg.asleep;
  // Retention keeps the array powered; no reset of contents occurs. [R3]
  assign RETAIN_STATE    = ctl_reg.asleep;
  // Writes are refused while recovering, reads still pass. [R8]
  assign RECOVERY_ACTIVE = ctl_reg.recovering;
  assign WRITE_BLOCK     = ctl_reg.recovering;
  assign READY           = ctl_reg.ready;

  // The status pins are checked against the synchronised request, since
  // the raw pin may change anywhere inside a clock period.
  a_entry_two_edges: // [R2]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (ctl_reg.state == AWAKE && req_sync) ##1 req_sync
        |=> SLEEP_ACTIVE)
    else $error("sleep not entered two edges after request");

  a_sleep_needs_req: // [R2]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      $rose(SLEEP_ACTIVE) |-> ($past(req_sync) && $past(req_sync, 2)))
    else $error("sleep entered without two sampled requests");

  a_entry_abort: // [R9]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (ctl_reg.state == ENTERING && !req_sync) |=> !SLEEP_ACTIVE)
    else $error("entry did not abort when request fell");

  a_abort_stays_ready: // [R9]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (ctl_reg.state == ENTERING && READY && !req_sync) |=> READY)
    else $error("aborted entry left normal operation");

  a_sleep_holds: // [R6]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (SLEEP_ACTIVE && req_sync) |=> SLEEP_ACTIVE)
    else $error("sleep left while request high");

  a_wake_needs_low: // [R6]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      $fell(SLEEP_ACTIVE) |-> !$past(req_sync))
    else $error("sleep left without a low request");

  a_resleep_entry: // [R6]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (RECOVERY_ACTIVE && req_sync)
        |=> (!READY && !RECOVERY_ACTIVE && !SLEEP_ACTIVE))
    else $error("request in recovery did not restart entry");

  a_outputs_float: // [R5]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      SLEEP_ACTIVE |-> (OUTPUT_DISABLE && DESELECT_FORCE
                        && INPUTS_BLOCKED && !READY))
    else $error("sleep without deselect and float");

  a_status_onehot: // [R5]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      $onehot0({SLEEP_ACTIVE, RECOVERY_ACTIVE, READY}))
    else $error("more than one power status active");

  a_retain_state: // [R3]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      SLEEP_ACTIVE |-> RETAIN_STATE)
    else $error("retention off while asleep");

  a_recovery_time: // [R4]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      $fell(SLEEP_ACTIVE) |-> (RECOVERY_ACTIVE && WRITE_BLOCK && !READY))
    else $error("ready before recovery time");

  a_recovery_ends: // [R4]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      ($fell(SLEEP_ACTIVE) && !req_sync) ##1 !req_sync
        |=> READY)
    else $error("recovery did not end");

  a_awake_ready: // [R4]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (ctl_reg.state == AWAKE) |-> READY)
    else $error("awake without normal operation");

  a_write_block: // [R8]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      RECOVERY_ACTIVE |-> (WRITE_BLOCK && !READY && !SLEEP_ACTIVE))
    else $error("writes open during recovery");

  a_idle_low: // [R1]
    assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (READY && !req_sync) |=> !SLEEP_ACTIVE)
    else $error("sleep without request");

  // Main scenarios: entry, abort, full recovery, re-entry from recovery
  // and an aborted re-entry that falls back to recovery.
  c_enter_sleep:
    cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      $rose(SLEEP_ACTIVE));

  c_abort_entry:
    cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      ctl_reg.state == ENTERING && !req_sync);

  c_full_recovery:
    cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      $fell(RECOVERY_ACTIVE) && READY);

  c_resleep:
    cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      RECOVERY_ACTIVE && req_sync);

  c_entry_fallback:
    cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      ctl_reg.state == ENTERING && !READY && !req_sync);
endmodule

// *** tb/sleep_host.sv ***
module sleep_host (
  // Clock and request pin.
  input  wire logic clk,
  output logic      req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle low in normal use.
  initial req = 1'b0;
  // This host never has a pending access, so it may raise at once.
  task automatic rise();
    @(posedge clk);
    #1 req = 1'b1;
  endtask
  task automatic fall();
    @(posedge clk);
    #1 req = 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        req;
  wire  [7:0]  vec;
  logic [7:0]  last;
  logic [39:0] notes[$];
  logic [39:0] got;
  logic [31:0] lfsr = 32'h67BF;
  int          cyc = 0;
  int          fails = 0;
  int          samples_checked = 0;
  int          k;
  sleep_host host (.clk(sys_clk), .req(req));
  sram_sleep_ctl dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .SLEEP_REQUEST(req),
    .SLEEP_ACTIVE(vec[7]), .DESELECT_FORCE(vec[6]),
    .INPUTS_BLOCKED(vec[5]), .OUTPUT_DISABLE(vec[4]),
    .RETAIN_STATE(vec[3]), .RECOVERY_ACTIVE(vec[2]),
    .WRITE_BLOCK(vec[1]), .READY(vec[0]));
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done();
    if (notes.size() != 0) fails++;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Every change of the status group must match the oldest note.
  always @(negedge sys_clk) begin
    if (rstn && vec !== last) begin
      got = {32'(cyc), vec};
      samples_checked++;
      if (notes.size() == 0) begin
        fails++;
        $display("MISMATCH t=%0t got %h expected none", $time, got);
      end else if (got !== notes[0]) begin
        fails++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, notes[0]);
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
    last = vec;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      // A one-cycle pulse must abort entry and leave the status alone.
      host.rise();
      host.fall();
      repeat (6) @(posedge sys_clk);
      host.rise();
      k = cyc;
      notes.push_back({32'(k + 4), 8'hF8});
      repeat (3 + lfsr[3:0]) @(posedge sys_clk);
      // A one-edge dip wakes the core, and the raised request re-enters.
      host.fall();
      host.rise();
      if (i[0]) begin
        // The re-entry is aborted and must fall back to recovery.
        host.fall();
        k = cyc;
        notes.push_back({32'(k + 1), 8'h06});
        notes.push_back({32'(k + 2), 8'h00});
        notes.push_back({32'(k + 3), 8'h06});
        notes.push_back({32'(k + 4), 8'h01});
      end else begin
        k = cyc;
        notes.push_back({32'(k + 2), 8'h06});
        notes.push_back({32'(k + 3), 8'h00});
        notes.push_back({32'(k + 4), 8'hF8});
        repeat (3 + lfsr[10:7]) @(posedge sys_clk);
        host.fall();
        k = cyc;
        notes.push_back({32'(k + 3), 8'h06});
        notes.push_back({32'(k + 4), 8'h01});
      end
      repeat (2 + lfsr[6:4]) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
    end
    test_done();
  end
endmodule
